// ==== rtl/list_pha_pkg.sv ====
// shared constants, register map and record layout for the event acquisition block
package list_pha_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 500;
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int FAST_PEAK_CLEAR_INPUT_TIME_NS = 600;
  localparam int FAST_PEAK_CLEAR_INPUT_CYC = FAST_PEAK_CLEAR_INPUT_TIME_NS / CLK_PERIOD_NS;
  localparam int MCS_BASE_NS = 5;
  localparam logic [7:0] MCS_STEP = 8'(CLK_PERIOD_NS / MCS_BASE_NS);
  localparam int TICK_10MS_US = 10000;
  localparam int TICK_10MS_CYC = TICK_10MS_US * 1000 / CLK_PERIOD_NS;
  // widths and depths
  localparam int STAMP_W = 40;
  localparam int EVCNT_W = 28;
  localparam int NCH = 16;
  localparam int FIFO_AW = 18;
  localparam int FIFO_DEPTH = 1 << FIFO_AW;
  localparam int HIST_AW = 17;
  localparam int ADC_W = 14;
  localparam logic [2:0] GAIN_MAX = 3'h5;
  localparam logic [2:0] GAIN_SHIFT0 = 3'h6;
  // register word addresses
  localparam logic [19:0] A_CTRL = 20'h00000;
  localparam logic [19:0] A_CHAN = 20'h00001;
  localparam logic [19:0] A_STATUS = 20'h00004;
  localparam logic [19:0] A_FIFO = 20'h00005;
  localparam logic [19:0] A_LEVEL = 20'h00006;
  localparam logic [19:0] A_EVCNT = 20'h00007;
  localparam logic [19:0] A_SIZE_PRE = 20'h00008;
  localparam logic [19:0] A_EV_PRE = 20'h00009;
  localparam logic [19:0] A_STAMP_LO = 20'h0000A;
  localparam logic [19:0] A_STAMP_HI = 20'h0000B;
  localparam logic [19:0] A_MCS = 20'h0000C;
  localparam logic [15:0] A_GAIN_BASE = 16'h0001;
  localparam logic [13:0] A_PRESET_BASE = 14'h0001;
  localparam logic [13:0] A_COUNT_BASE = 14'h0002;
  localparam int HIST_SEL_BIT = 19;
  // status bits and register reset values
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_NOTIFY = 2;
  localparam int ST_LOST = 3;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CHAN_RST = 32'hFFFFFFFF;
  // preset kinds
  localparam int PK_REAL = 0;
  localparam int PK_LIVE = 1;
  localparam int PK_PEAK = 2;
  localparam int PK_AREA = 3;

  typedef enum logic [1:0] {LIST_OFF, LIST_GATED, LIST_FREE, LIST_TRIG} list_mode_t;
  typedef enum logic [1:0] {WR_IDLE, WR_HEAD, WR_TAIL} wr_state_t;

  typedef struct packed {
    logic [3:0] module_idx;
    logic [3:0] trig_sel;
    logic run;
    logic [2:0] base_sel;
    logic lag_fmt;
    list_mode_t list_mode;
    logic pha_en;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] module_idx;
    logic [3:0] chan;
    logic coinc;
    logic [STAMP_W-1:0] stamp;
    logic [ADC_W-1:0] value;
  } list_rec_t;
endpackage

// ==== rtl/event_fifo.sv ====
// event fifo with head word visible for a read in the same cycle
`timescale 1ns/1ns
module event_fifo
  import list_pha_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // write side
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  // read side
  input wire logic rd_en,
  output logic [31:0] head,
  // state
  output logic [FIFO_AW:0] level,
  output logic full,
  output logic empty
);
  logic [31:0] mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_q;
  logic [FIFO_AW-1:0] rp_q;
  logic [FIFO_AW:0] cnt_q;
  logic do_wr;
  logic do_rd;

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == (FIFO_AW+1)'(FIFO_DEPTH));
  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;
  assign head = mem[rp_q];
  assign level = cnt_q;

  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
    begin
      mem[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_wr)
        wp_q <= wp_q + 1'b1;
      if (do_rd)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (FIFO_AW+1)'(do_wr) - (FIFO_AW+1)'(do_rd);
    end
  end
endmodule

// ==== rtl/stamp_timer.sv ====
// absolute and trigger-lag stamp counters plus the scaler time base
`timescale 1ns/1ns
module stamp_timer
  import list_pha_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic [2:0] base_sel,
  input wire logic sync_clr,
  input wire logic trig,
  // counts
  output logic [STAMP_W-1:0] stamp_abs,
  output logic [STAMP_W-1:0] stamp_lag,
  output logic [31:0] mcs_time
);
  logic [7:0] acc_q;
  logic [7:0] sum;
  logic [7:0] div;
  logic [7:0] ticks;

  // base period in 5 ns units: 5,10,20,50,100,200,500,1000 ns
  function automatic logic [7:0] base_units(input logic [2:0] sel);
    case (sel)
      3'h0: base_units = 8'h01;
      3'h1: base_units = 8'h02;
      3'h2: base_units = 8'h04;
      3'h3: base_units = 8'h0A;
      3'h4: base_units = 8'h14;
      3'h5: base_units = 8'h28;
      3'h6: base_units = 8'h64;
      default: base_units = 8'hC8;
    endcase
  endfunction

  always_comb
  begin
    div = base_units(base_sel);
    sum = acc_q + MCS_STEP;
    ticks = sum / div;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_q <= '0;
      stamp_abs <= '0;
      stamp_lag <= '0;
      mcs_time <= '0;
    end
    else
    begin
      acc_q <= sum % div;
      mcs_time <= mcs_time + 32'(MCS_STEP);
      if (sync_clr)
        stamp_abs <= '0;
      else
        stamp_abs <= stamp_abs + STAMP_W'(ticks);
      if (sync_clr)
        stamp_lag <= '0;
      else if (trig)
        stamp_lag <= STAMP_W'(ticks);
      else
        stamp_lag <= stamp_lag + STAMP_W'(ticks);
    end
  end
endmodule

// ==== rtl/list_pha_acq.sv ====
// event acquisition: list records, pulse height histograms, presets and register port
`timescale 1ns/1ns
module list_pha_acq
  import list_pha_pkg::*;
#(
  parameter int TICK_CYC = TICK_10MS_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // converter side
  input wire logic peak_valid,
  input wire logic [3:0] peak_chan,
  input wire logic [ADC_W-1:0] peak_value,
  output logic adc_enable,
  output logic peak_clear,
  // control inputs
  input wire logic common_gate_input,
  input wire logic [NCH-1:0] channel_gate_trigger_inputs,
  input wire logic fast_peak_clear_input,
  input wire logic veto_input,
  input wire logic sync_stamp_reset,
  // status outputs
  output logic busy_out,
  output logic list_notify_out
);
  ctrl_t ctrl_q;
  logic [NCH-1:0] chan_en_q;
  logic [NCH-1:0] gate_mask_q;
  logic [2:0] gain_q [NCH];
  logic [31:0] preset_q [NCH][4];
  logic [31:0] count_q [NCH][4];
  logic [31:0] size_pre_q;
  logic [EVCNT_W-1:0] ev_pre_q;
  logic [EVCNT_W-1:0] evcnt_q;
  logic [31:0] words_q;
  logic notify_q;
  logic lost_q;
  logic gate_prev_q;
  logic [NCH-1:0] trg_prev_q;
  logic armed_q;
  logic [NCH-1:0] stop_q;
  logic [31:0] hist [1 << HIST_AW];
  logic [31:0] tick_cnt_q;
  logic tick_q;
  list_rec_t rec_q;
  wr_state_t wst_q;
  logic hist_pend_q;
  logic [HIST_AW-1:0] hist_addr_q;
  logic [31:0] fifo_head;
  logic [FIFO_AW:0] fifo_level;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_wr;
  logic [31:0] fifo_wdata;
  logic fifo_rd;
  logic [STAMP_W-1:0] stamp_abs;
  logic [STAMP_W-1:0] stamp_lag;
  logic [31:0] mcs_time;
  logic trig_pulse;
  logic gate_rise;
  logic ev_ok;
  logic list_take;
  logic hist_take;
  logic room;
  logic [12:0] bin;
  logic [31:0] hist_next;

  // scale a raw peak to the channel's bin count
  function automatic logic [12:0] gain_scale(input logic [ADC_W-1:0] v, input logic [2:0] g);
    logic [2:0] gc;
    gc = (g > GAIN_MAX) ? GAIN_MAX : g;
    gain_scale = 13'(v >> (GAIN_SHIFT0 - gc));
  endfunction

  function automatic logic wr_hit(input logic [19:0] a, input logic [19:0] ref_a);
    wr_hit = (a == ref_a);
  endfunction

  event_fifo u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(fifo_wr),
    .wr_data(fifo_wdata),
    .rd_en(fifo_rd),
    .head(fifo_head),
    .level(fifo_level),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  stamp_timer u_stamp (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .base_sel(ctrl_q.base_sel),
    .sync_clr(sync_stamp_reset),
    .trig(trig_pulse),
    .stamp_abs(stamp_abs),
    .stamp_lag(stamp_lag),
    .mcs_time(mcs_time)
  );

  // event qualification
  always_comb
  begin
    trig_pulse = channel_gate_trigger_inputs[ctrl_q.trig_sel] && !trg_prev_q[ctrl_q.trig_sel];
    gate_rise = common_gate_input && !gate_prev_q;
    room = ((FIFO_AW+1)'(FIFO_DEPTH) - fifo_level) >= (FIFO_AW+1)'(2);
    ev_ok = peak_valid && ctrl_q.run && !veto_input && !fast_peak_clear_input;
    list_take = 1'b0;
    case (ctrl_q.list_mode)
      LIST_FREE: list_take = ev_ok && chan_en_q[peak_chan];
      LIST_GATED: list_take = ev_ok && common_gate_input && gate_mask_q[peak_chan];
      LIST_TRIG: list_take = ev_ok && chan_en_q[peak_chan] && (armed_q || trig_pulse);
      default: list_take = 1'b0;
    endcase
    list_take = list_take && room && (wst_q == WR_IDLE);
    hist_take = ev_ok && ctrl_q.pha_en && chan_en_q[peak_chan] && !stop_q[peak_chan];
    bin = gain_scale(peak_value, gain_q[peak_chan]);
    hist_next = hist[hist_addr_q] + 32'h00000001;
  end

  // record build and two-word write, done within a few cycles of the peak
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rec_q <= '0;
      wst_q <= WR_IDLE;
    end
    else
    begin
      case (wst_q)
        WR_IDLE:
          if (list_take)
          begin
            rec_q.module_idx <= ctrl_q.module_idx;
            rec_q.chan <= peak_chan;
            rec_q.value <= 14'(gain_scale(peak_value, gain_q[peak_chan]));
            rec_q.stamp <= ctrl_q.lag_fmt ? (trig_pulse ? '0 : stamp_lag) : stamp_abs;
            rec_q.coinc <= ctrl_q.lag_fmt && (trig_pulse || stamp_lag == '0);
            wst_q <= WR_HEAD;
          end
        WR_HEAD: wst_q <= WR_TAIL;
        WR_TAIL: wst_q <= WR_IDLE;
        default: wst_q <= WR_IDLE;
      endcase
    end
  end

  always_comb
  begin
    fifo_wr = (wst_q == WR_HEAD) || (wst_q == WR_TAIL);
    if (wst_q == WR_HEAD)
      fifo_wdata = {rec_q.module_idx, rec_q.chan, rec_q.coinc, rec_q.stamp[39:32], 1'b0,
                    rec_q.value};
    else
      fifo_wdata = rec_q.stamp[31:0];
    fifo_rd = reg_rd && wr_hit(reg_addr, A_FIFO);
  end

  // edges, arming, event counter and list notification
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gate_prev_q <= 1'b0;
      trg_prev_q <= '0;
      armed_q <= 1'b0;
      evcnt_q <= '0;
      words_q <= '0;
      notify_q <= 1'b0;
      lost_q <= 1'b0;
    end
    else
    begin
      gate_prev_q <= common_gate_input;
      trg_prev_q <= channel_gate_trigger_inputs;
      if (!ctrl_q.run)
        armed_q <= 1'b0;
      else if (trig_pulse)
        armed_q <= 1'b1;
      if (reg_wr && wr_hit(reg_addr, A_EVCNT))
        evcnt_q <= '0;
      else if (gate_rise && ctrl_q.run)
        evcnt_q <= evcnt_q + 1'b1;
      if (reg_wr && wr_hit(reg_addr, A_STATUS))
        words_q <= '0;
      else if (fifo_wr)
        words_q <= words_q + 32'h00000001;
      if ((size_pre_q != '0 && words_q >= size_pre_q) ||
          (ev_pre_q != '0 && evcnt_q >= ev_pre_q))
        notify_q <= 1'b1;
      else if (reg_wr && wr_hit(reg_addr, A_STATUS) && reg_wdata[ST_NOTIFY])
        notify_q <= 1'b0;
      if (peak_valid && ctrl_q.run && ctrl_q.list_mode != LIST_OFF && !room)
        lost_q <= 1'b1;
      else if (reg_wr && wr_hit(reg_addr, A_STATUS) && reg_wdata[ST_LOST])
        lost_q <= 1'b0;
    end
  end

  // histogram read-modify-write
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hist_pend_q <= 1'b0;
      hist_addr_q <= '0;
    end
    else
    begin
      hist_pend_q <= hist_take;
      if (hist_take)
        hist_addr_q <= {peak_chan, bin};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (hist_pend_q)
      hist[hist_addr_q] <= hist_next;
    else if (reg_wr && reg_addr[HIST_SEL_BIT])
      hist[reg_addr[HIST_AW-1:0]] <= reg_wdata;
  end

  // 10 ms tick for real and live time
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
      if (tick_cnt_q == 32'(TICK_CYC - 1))
        tick_cnt_q <= '0;
      else
        tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end

  // per-channel preset counters and stop flags
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int c = 0; c < NCH; c++)
        for (int k = 0; k < 4; k++)
          count_q[c][k] <= '0;
      stop_q <= '0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (tick_q && ctrl_q.run && ctrl_q.pha_en && !stop_q[c])
        begin
          count_q[c][PK_REAL] <= count_q[c][PK_REAL] + 32'h00000001;
          if (!veto_input && !fifo_full)
            count_q[c][PK_LIVE] <= count_q[c][PK_LIVE] + 32'h00000001;
        end
        if (hist_pend_q && hist_addr_q[HIST_AW-1:HIST_AW-4] == 4'(c))
        begin
          count_q[c][PK_AREA] <= count_q[c][PK_AREA] + 32'h00000001;
          if (hist_next > count_q[c][PK_PEAK])
            count_q[c][PK_PEAK] <= hist_next;
        end
        if (reg_wr && wr_hit(reg_addr, A_CTRL) && !reg_wdata[7])
          stop_q[c] <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
          if (reg_wr && reg_addr[19:6] == A_COUNT_BASE && reg_addr[5:2] == 4'(c) &&
              reg_addr[1:0] == 2'(k))
            count_q[c][k] <= '0;
          if (preset_q[c][k] != '0 && count_q[c][k] >= preset_q[c][k])
            stop_q[c] <= 1'b1;
        end
      end
    end
  end

  // register writes
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= CTRL_RST[15:0];
      chan_en_q <= CHAN_RST[15:0];
      gate_mask_q <= CHAN_RST[31:16];
      size_pre_q <= '0;
      ev_pre_q <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        gain_q[c] <= GAIN_MAX;
        for (int k = 0; k < 4; k++)
          preset_q[c][k] <= '0;
      end
    end
    else if (reg_wr)
    begin
      if (wr_hit(reg_addr, A_CTRL))
        ctrl_q <= reg_wdata[15:0];
      if (wr_hit(reg_addr, A_CHAN))
      begin
        chan_en_q <= reg_wdata[15:0];
        gate_mask_q <= reg_wdata[31:16];
      end
      if (wr_hit(reg_addr, A_SIZE_PRE))
        size_pre_q <= reg_wdata;
      if (wr_hit(reg_addr, A_EV_PRE))
        ev_pre_q <= reg_wdata[EVCNT_W-1:0];
      if (reg_addr[19:4] == A_GAIN_BASE)
        gain_q[reg_addr[3:0]] <= reg_wdata[2:0];
      if (reg_addr[19:6] == A_PRESET_BASE)
        preset_q[reg_addr[5:2]][reg_addr[1:0]] <= reg_wdata;
    end
  end

  // register reads, data valid one cycle after the strobe
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      reg_rdata <= '0;
      if (reg_addr[HIST_SEL_BIT])
        reg_rdata <= hist[reg_addr[HIST_AW-1:0]];
      else if (reg_addr[19:6] == A_PRESET_BASE)
        reg_rdata <= preset_q[reg_addr[5:2]][reg_addr[1:0]];
      else if (reg_addr[19:6] == A_COUNT_BASE)
        reg_rdata <= count_q[reg_addr[5:2]][reg_addr[1:0]];
      else if (reg_addr[19:4] == A_GAIN_BASE)
        reg_rdata <= {29'h0, gain_q[reg_addr[3:0]]};
      else
        case (reg_addr)
          A_CTRL: reg_rdata <= {16'h0, ctrl_q};
          A_CHAN: reg_rdata <= {gate_mask_q, chan_en_q};
          A_STATUS: reg_rdata <= {stop_q, 12'h0, lost_q, notify_q, fifo_full, fifo_empty};
          A_FIFO: reg_rdata <= fifo_empty ? 32'h00000000 : fifo_head;
          A_LEVEL: reg_rdata <= 32'(fifo_level);
          A_EVCNT: reg_rdata <= {4'h0, evcnt_q};
          A_SIZE_PRE: reg_rdata <= size_pre_q;
          A_EV_PRE: reg_rdata <= {4'h0, ev_pre_q};
          A_STAMP_LO: reg_rdata <= stamp_abs[31:0];
          A_STAMP_HI: reg_rdata <= {24'h0, stamp_abs[39:32]};
          A_MCS: reg_rdata <= mcs_time;
          default: reg_rdata <= '0;
        endcase
    end
  end

  // pin outputs
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      adc_enable <= 1'b0;
      peak_clear <= 1'b0;
      busy_out <= 1'b0;
      list_notify_out <= 1'b0;
    end
    else
    begin
      adc_enable <= ctrl_q.run && !veto_input;
      peak_clear <= fast_peak_clear_input;
      busy_out <= fifo_full;
      list_notify_out <= notify_q;
    end
  end
endmodule

// ==== dv/list_pha_acq_props.sv ====
// port-level assertions for the event acquisition block
`timescale 1ns/1ns
module list_pha_acq_props
  import list_pha_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // side signals
  input wire logic fast_peak_clear_input,
  input wire logic peak_clear,
  input wire logic veto_input,
  input wire logic adc_enable,
  input wire logic busy_out,
  input wire logic list_notify_out
);
  logic run_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // shadow of the run bit
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      run_q <= 1'b0;
    else if (reg_wr && reg_addr == A_CTRL)
      run_q <= reg_wdata[7];
  end
  property p_clear;
    fast_peak_clear_input |=> peak_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("fast clear not seen");
  property p_veto;
    veto_input |=> !adc_enable;
  endproperty
  a_veto: assert property (p_veto) else $error("conversion active in veto");
  property p_run_on;
    (run_q && !veto_input) [*2] |-> adc_enable;
  endproperty
  a_run_on: assert property (p_run_on) else $error("converter idle while running");
  property p_run_off;
    !run_q |=> !adc_enable;
  endproperty
  a_run_off: assert property (p_run_off) else $error("converter on while stopped");
  property p_unmapped;
    reg_rd && reg_addr == 20'h00003 |=> reg_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_busy;
    reg_rd && reg_addr == A_STATUS |=> reg_rdata[ST_FULL] == busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("busy differs from full flag");
  property p_notify;
    reg_rd && reg_addr == A_STATUS |=> reg_rdata[ST_NOTIFY] == list_notify_out;
  endproperty
  a_notify: assert property (p_notify) else $error("notify pin differs from flag");
  property p_rst;
    $fell(sys_rst) |-> !busy_out && !list_notify_out;
  endproperty
  a_rst: assert property (p_rst) else $error("status pins set after reset");
  c_pop: cover property (reg_rd && reg_addr == A_FIFO);
  c_veto: cover property (veto_input);
  c_notify: cover property (list_notify_out);
endmodule
bind list_pha_acq list_pha_acq_props u_list_pha_acq_props (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .fast_peak_clear_input(fast_peak_clear_input),
  .peak_clear(peak_clear),
  .veto_input(veto_input),
  .adc_enable(adc_enable),
  .busy_out(busy_out),
  .list_notify_out(list_notify_out)
);

// ==== dv/host_model.sv ====
// register bus master model for the acquisition block
`timescale 1ns/1ns
module host_model
  import list_pha_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // register port
  output logic [19:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr = 20'h00000;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write cycle, strobe one clock
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read cycle, data taken in the following cycle
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ==== dv/list_pha_acq_bench.sv ====
// self-checking bench for the event acquisition block
`timescale 1ns/1ns
module list_pha_acq_bench;
  import list_pha_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic peak_valid = 1'b0;
  logic [3:0] peak_chan = 4'h0;
  logic [ADC_W-1:0] peak_value = 14'h0000;
  logic common_gate_input = 1'b0;
  logic [NCH-1:0] channel_gate_trigger_inputs = 16'h0000;
  logic fast_peak_clear_input = 1'b0;
  logic veto_input = 1'b0;
  logic sync_stamp_reset = 1'b0;
  logic adc_enable;
  logic peak_clear;
  logic busy_out;
  logic list_notify_out;
  logic [31:0] d, h1, t1, h2, t2;
  int n_fail = 0;
  int checks_done = 0;
  always #25 sys_clk = ~sys_clk;
  host_model u_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  list_pha_acq #(.TICK_CYC(20)) u_list_pha_acq (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .peak_valid(peak_valid), .peak_chan(peak_chan),
    .peak_value(peak_value), .adc_enable(adc_enable), .peak_clear(peak_clear),
    .common_gate_input(common_gate_input),
    .channel_gate_trigger_inputs(channel_gate_trigger_inputs),
    .fast_peak_clear_input(fast_peak_clear_input), .veto_input(veto_input),
    .sync_stamp_reset(sync_stamp_reset), .busy_out(busy_out),
    .list_notify_out(list_notify_out));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one converter result, then room for the two-word write
  task automatic ev(input logic [3:0] c, input logic [13:0] v, input logic [15:0] g);
    @(posedge sys_clk);
    peak_valid <= 1'b1;
    peak_chan <= c;
    peak_value <= v;
    channel_gate_trigger_inputs <= g;
    @(posedge sys_clk);
    peak_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic pop(output logic [31:0] h, output logic [31:0] t);
    u_host_model.rd(A_FIFO, h);
    u_host_model.rd(A_FIFO, t);
  endtask
  task automatic t_defaults;
    u_host_model.rd(A_CTRL, d);
    chk(d, CTRL_RST, "ctrl reset");
    u_host_model.rd(A_CHAN, d);
    chk(d, CHAN_RST, "chan reset");
    u_host_model.rd(20'h00003, d);
    chk(d, 32'h00000000, "unmapped");
    u_host_model.rd(A_STATUS, d);
    chk(d & 32'h00000003, 32'h00000001, "empty flags");
  endtask
  task automatic t_free;
    u_host_model.wr(A_CTRL, 32'h000030B4);
    ev(4'h5, 14'h1234, 16'h0000);
    ev(4'h5, 14'h1236, 16'h0000);
    u_host_model.rd(A_LEVEL, d);
    chk(d, 32'h00000004, "free level");
    pop(h1, t1);
    pop(h2, t2);
    chk(h1 & 32'hFF807FFF, 32'h3500091A, "record head");
    chk(t2 - t1, 32'h00000005, "stamp step");
    @(posedge sys_clk);
    veto_input <= 1'b1;
    ev(4'h1, 14'h0100, 16'h0000);
    veto_input <= 1'b0;
    fast_peak_clear_input <= 1'b1;
    ev(4'h1, 14'h0100, 16'h0000);
    fast_peak_clear_input <= 1'b0;
    u_host_model.rd(A_LEVEL, d);
    chk(d, 32'h00000000, "veto and clear drop");
    u_host_model.wr(20'h00012, 32'h00000000);
    ev(4'h2, 14'h3FFF, 16'h0000);
    pop(h1, t1);
    chk(h1 & 32'h00003FFF, 32'h000000FF, "gain 256");
    u_host_model.wr(A_CTRL, 32'h00000000);
  endtask
  task automatic t_gated;
    u_host_model.wr(A_STATUS, 32'h0000000C);
    u_host_model.wr(A_SIZE_PRE, 32'h00000002);
    u_host_model.wr(A_CHAN, 32'h0002FFFF);
    u_host_model.wr(A_CTRL, 32'h000000B2);
    @(negedge sys_clk);
    chk({31'h0, list_notify_out}, 32'h00000000, "notify early");
    ev(4'h1, 14'h0200, 16'h0000);
    common_gate_input <= 1'b1;
    ev(4'h2, 14'h0200, 16'h0000);
    ev(4'h1, 14'h0200, 16'h0000);
    u_host_model.rd(A_LEVEL, d);
    chk(d, 32'h00000002, "gated level");
    chk({31'h0, list_notify_out}, 32'h00000001, "notify");
    u_host_model.rd(A_EVCNT, d);
    chk(d, 32'h00000001, "event count");
    common_gate_input <= 1'b0;
    pop(h1, t1);
    chk(h1 & 32'h0F000000, 32'h01000000, "gated chan");
    u_host_model.wr(A_CTRL, 32'h00000000);
  endtask
  task automatic t_trig;
    u_host_model.wr(A_CTRL, 32'h000004BE);
    ev(4'h3, 14'h0400, 16'h0000);
    ev(4'h3, 14'h0400, 16'h0010);
    ev(4'h3, 14'h0400, 16'h0010);
    u_host_model.rd(A_LEVEL, d);
    chk(d, 32'h00000004, "trig level");
    pop(h1, t1);
    pop(h2, t2);
    chk(h1 & 32'h00800000, 32'h00800000, "coinc set");
    chk(h2 & 32'h00800000, 32'h00000000, "coinc clear");
    chk(t1, 32'h00000000, "lag at trigger");
    chk(t2 - t1, 32'h00000005, "lag step");
    channel_gate_trigger_inputs <= 16'h0000;
    u_host_model.wr(A_CTRL, 32'h00000000);
  endtask
  task automatic t_pha;
    u_host_model.wr(20'h80080, 32'h00000000);
    u_host_model.wr(20'h00043, 32'h00000001);
    u_host_model.wr(A_CTRL, 32'h00000085);
    sync_stamp_reset <= 1'b1;
    @(posedge sys_clk);
    sync_stamp_reset <= 1'b0;
    u_host_model.rd(A_STAMP_LO, d);
    chk(d, 32'h0000000A, "stamp after sync");
    ev(4'h0, 14'h0100, 16'h0000);
    u_host_model.rd(20'h80080, d);
    chk(d, 32'h00000001, "histogram bin");
    u_host_model.rd(A_LEVEL, d);
    chk(d, 32'h00000002, "list beside pha");
    ev(4'h0, 14'h0100, 16'h0000);
    u_host_model.rd(20'h80080, d);
    chk(d, 32'h00000001, "bin after area preset");
    u_host_model.rd(A_STATUS, d);
    chk(d & 32'h00010000, 32'h00010000, "stop flag");
    u_host_model.rd(A_MCS, d);
    u_host_model.rd(A_MCS, h1);
    chk(h1 - d, 32'h00000014, "scaler step");
    u_host_model.rd(20'h00084, d);
    repeat (198) @(posedge sys_clk);
    u_host_model.rd(20'h00084, h1);
    chk(h1 - d, 32'h0000000A, "real time ticks");
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_defaults();
    t_free();
    t_gated();
    t_trig();
    t_pha();
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
endmodule
